// file: hw/pomux_pkg.sv
package pomux_pkg;
    localparam int POMUX_NPINS = 16;
    localparam int POMUX_NCN = 24;
    localparam int POMUX_NPERIPH = 2;
    localparam logic [3:0] OFS_DIR = 4'h0;
    localparam logic [3:0] OFS_LEVEL = 4'h1;
    localparam logic [3:0] OFS_LATCH = 4'h2;
    localparam logic [3:0] OFS_ODC = 4'h3;
    localparam logic [3:0] OFS_CNEN_LO = 4'h4;
    localparam logic [3:0] OFS_CNEN_HI = 4'h5;
    localparam logic [3:0] OFS_CNPU_LO = 4'h6;
    localparam logic [3:0] OFS_CNPU_HI = 4'h7;
    localparam logic [3:0] OFS_CNFLAG = 4'h8;
    localparam logic [15:0] RST_DIR = 16'hFFFF;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
    localparam int CN_HI_BITS = 8;
    typedef struct packed {
        logic [POMUX_NPINS-1:0] en;
        logic [POMUX_NPINS-1:0] module_ctl;
        logic [POMUX_NPINS-1:0] out;
        logic [POMUX_NPINS-1:0] oe;
    } pomux_periph_s;
    typedef struct packed {
        logic [3:0] addr;
        logic read;
        logic write;
        logic [31:0] wdata;
    } pomux_bus_s;
endpackage : pomux_pkg

// file: hw/pomux_top.sv
// Behaviour
// R1: enabled peripheral owns pin data and enable
// R2: module-controlled peripheral disables port driver
// R3: user-settable peripheral keeps direction bit control
// R4: level register reads actual pin always
// R5: software sets converter pin config bits; no such bits here, every pin is a port
// R6: lowest index enabled peripheral wins pin
// R7: input-only functions never claim driver
// R8: software drives input functions via port
// R9: serial peripherals ignore port writes
// R10: latch writes drive capture input internally
// R11: latch writes trigger enabled external interrupt
// R12: serial pins ignore level and direction
// R13: unused function pin works as output
// R14: change on selected input raises request
// R15: change interrupts only with enable bit
// R16: pull-up per change pin enable bit
// R17: direction one input, zero output, reset inputs
// R18: level read pins, write loads latch
// R19: latch read returns latch, write updates
// R20: open-drain bit makes output drive low only
// R21: synchronise, compare, sticky flag until cleared
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module pomux_top
    import pomux_pkg::*;
#(
    parameter int NPINS = POMUX_NPINS,
    parameter int NPER = POMUX_NPERIPH,
    parameter int NCN = POMUX_NCN
) (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic [NPER-1:0][NPINS-1:0] PERIPH_EN,
    input wire logic [NPER-1:0][NPINS-1:0] PERIPH_MODULE_CTL,
    input wire logic [NPER-1:0][NPINS-1:0] PERIPH_OUT,
    input wire logic [NPER-1:0][NPINS-1:0] PERIPH_OE,
    input wire logic [NPINS-1:0] PIN_IN,
    output logic [NPINS-1:0] PIN_OUT,
    output logic [NPINS-1:0] PIN_OE_N,
    output logic [NPINS-1:0] PERIPH_IN,
    input wire logic [NCN-1:0] CN_IN,
    output logic [NCN-1:0] CN_PULLUP_EN,
    output logic CN_IRQ
);
    logic [NPINS-1:0] dir_r, dir_nxt, lat_r, lat_nxt, odc_r, odc_nxt;
    logic [NCN-1:0] cnen_r, cnen_nxt, cnpu_r, cnpu_nxt;
    logic [NCN-1:0] cn_s1_r, cn_s2_r, cn_prev_r;
    logic [NCN-1:0] cn_s1_nxt, cn_s2_nxt, cn_prev_nxt;
    logic cnflag_r, cnflag_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic ack_r, ack_nxt;
    logic wr_go, rd_go, cn_change;
    logic [NPINS-1:0] own_any, own_mod, own_out, own_oe;
    logic [NPINS-1:0] drv_val, drv_en;

    function automatic logic [31:0] zext16(input logic [NPINS-1:0] v);
        zext16 = 32'h00000000;
        zext16[NPINS-1:0] = v;
    endfunction : zext16

    // one wait state: request answered on the second edge, keeps read data registered
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;
    assign wr_go = AVS_WRITE & ack_r;
    assign rd_go = AVS_READ & ~ack_r;
    assign AVS_READDATA = rdata_r;

    // priority mux per pin: index 0 is listed first in the pin name
    genvar gp;
    generate
        for (gp = 0; gp < NPINS; gp++) begin : g_pin
            always_comb begin
                own_any[gp] = 1'b0;
                own_mod[gp] = 1'b0;
                own_out[gp] = 1'b0;
                own_oe[gp] = 1'b0;
                for (int k = NPER - 1; k >= 0; k--) begin
                    // input-only functions leave module_ctl low and never own the driver R7
                    if (PERIPH_EN[k][gp] && PERIPH_MODULE_CTL[k][gp]) begin // R6
                        own_any[gp] = 1'b1;
                        own_mod[gp] = 1'b1;
                        own_out[gp] = PERIPH_OUT[k][gp];
                        own_oe[gp] = PERIPH_OE[k][gp];
                    end
                end
            end
            // serial owners drop the port path; direction and latch are ignored R1 R2 R9 R12
            assign drv_val[gp] = own_mod[gp] ? own_out[gp] : lat_r[gp]; // R1
            // user-settable or unused function: direction bit rules R3 R13 R17
            assign drv_en[gp] = own_mod[gp] ? own_oe[gp] : ~dir_r[gp]; // R2 R3
            // open drain: only a low level is driven R20
            assign PIN_OUT[gp] = odc_r[gp] ? 1'b0 : drv_val[gp];
            assign PIN_OE_N[gp] = ~(drv_en[gp] & (~odc_r[gp] | ~drv_val[gp])); // R20
            // port-driven level loops to capture, interrupt and fault inputs R8 R10 R11
            assign PERIPH_IN[gp] = (drv_en[gp] & ~own_mod[gp]) ? lat_r[gp] : PIN_IN[gp]; // R7
        end
    endgenerate

    always_comb begin
        dir_nxt = dir_r;
        lat_nxt = lat_r;
        odc_nxt = odc_r;
        cnen_nxt = cnen_r;
        cnpu_nxt = cnpu_r;
        rdata_nxt = rdata_r;
        ack_nxt = (AVS_READ | AVS_WRITE) & ~ack_r;
        if (wr_go) begin
            case (AVS_ADDRESS)
                OFS_DIR: dir_nxt = AVS_WRITEDATA[NPINS-1:0]; // R17
                OFS_LEVEL: lat_nxt = AVS_WRITEDATA[NPINS-1:0]; // R18
                OFS_LATCH: lat_nxt = AVS_WRITEDATA[NPINS-1:0]; // R19
                OFS_ODC: odc_nxt = AVS_WRITEDATA[NPINS-1:0];
                OFS_CNEN_LO: cnen_nxt[15:0] = AVS_WRITEDATA[15:0]; // R15
                OFS_CNEN_HI: cnen_nxt[NCN-1:16] = AVS_WRITEDATA[CN_HI_BITS-1:0];
                OFS_CNPU_LO: cnpu_nxt[15:0] = AVS_WRITEDATA[15:0]; // R16
                OFS_CNPU_HI: cnpu_nxt[NCN-1:16] = AVS_WRITEDATA[CN_HI_BITS-1:0];
                default: ;
            endcase
        end
        if (rd_go) begin
            case (AVS_ADDRESS)
                OFS_DIR: rdata_nxt = zext16(dir_r);
                OFS_LEVEL: rdata_nxt = zext16(PIN_IN); // R4 R18
                OFS_LATCH: rdata_nxt = zext16(lat_r); // R19
                OFS_ODC: rdata_nxt = zext16(odc_r);
                OFS_CNEN_LO: rdata_nxt = {16'h0000, cnen_r[15:0]};
                OFS_CNEN_HI: rdata_nxt = {24'h000000, cnen_r[NCN-1:16]};
                OFS_CNPU_LO: rdata_nxt = {16'h0000, cnpu_r[15:0]};
                OFS_CNPU_HI: rdata_nxt = {24'h000000, cnpu_r[NCN-1:16]};
                OFS_CNFLAG: rdata_nxt = {31'h00000000, cnflag_r};
                default: rdata_nxt = RD_UNMAPPED;
            endcase
        end
    end

    // a change in the clearing cycle keeps the flag set R21
    assign cn_change = |((cn_s2_r ^ cn_prev_r) & cnen_r); // R14 R15
    always_comb begin
        cnflag_nxt = cnflag_r;
        if (wr_go && AVS_ADDRESS == OFS_CNFLAG && AVS_WRITEDATA[0]) begin
            cnflag_nxt = 1'b0;
        end
        if (cn_change) begin
            cnflag_nxt = 1'b1; // R21
        end
    end
    assign CN_IRQ = cnflag_r; // R14
    assign CN_PULLUP_EN = cnpu_r; // R16

    // two flops ahead of the compare stage, only the second one is read R21
    always_comb begin
        cn_s1_nxt = CN_IN;
        cn_s2_nxt = cn_s1_r;
        cn_prev_nxt = cn_s2_r;
    end

    // port and change-notify control registers
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            dir_r <= RST_DIR;
            lat_r <= RST_ZERO;
            odc_r <= RST_ZERO;
            cnen_r <= '0;
            cnpu_r <= '0;
        end else begin
            dir_r <= dir_nxt;
            lat_r <= lat_nxt;
            odc_r <= odc_nxt;
            cnen_r <= cnen_nxt;
            cnpu_r <= cnpu_nxt;
        end
    end

    // bus answer registers
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_r <= RD_UNMAPPED;
            ack_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            ack_r <= ack_nxt;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnflag_r <= 1'b0;
            cn_s1_r <= '0;
            cn_s2_r <= '0;
            cn_prev_r <= '0;
        end else begin
            cnflag_r <= cnflag_nxt;
            cn_s1_r <= cn_s1_nxt;
            cn_s2_r <= cn_s2_nxt;
            cn_prev_r <= cn_prev_nxt;
        end
    end

    a_cn_flag_set: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        cn_change |=> cnflag_r) else $error("change did not set flag"); // R21
    a_cn_masked: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (cnen_r == '0 && !cnflag_r && !(wr_go && AVS_ADDRESS == OFS_CNEN_LO)
         && !(wr_go && AVS_ADDRESS == OFS_CNEN_HI)) |=> !cnflag_r)
        else $error("masked change set flag"); // R15
    a_cn_input_path: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        ($changed(cn_s2_r[0]) && cnen_r[0]) |=> CN_IRQ)
        else $error("irq missing after change"); // R14
    a_dir_output: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (own_mod == '0 && odc_r == '0) |-> (PIN_OE_N == dir_r && PIN_OUT == lat_r))
        else $error("port path wrong"); // R17
    a_module_owns: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        own_mod[0] && !odc_r[0] |-> (PIN_OUT[0] == own_out[0] && PIN_OE_N[0] == !own_oe[0]))
        else $error("module owner lost pin"); // R2
    a_prio_first: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (PERIPH_EN[0][0] && PERIPH_MODULE_CTL[0][0]) |-> own_out[0] == PERIPH_OUT[0][0])
        else $error("priority wrong"); // R6
    a_od_low_only: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        odc_r[0] |-> (PIN_OUT[0] == 1'b0 && (PIN_OE_N[0] || !drv_val[0])))
        else $error("open drain drove high"); // R20
    a_loopback: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (!own_mod[0] && !dir_r[0]) |-> PERIPH_IN[0] == lat_r[0])
        else $error("loopback broken"); // R10
    a_latch_read: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (rd_go && AVS_ADDRESS == OFS_LATCH) |=> AVS_READDATA[NPINS-1:0] == $past(lat_r))
        else $error("latch read wrong"); // R19
    a_level_read: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (rd_go && AVS_ADDRESS == OFS_LEVEL) |=> AVS_READDATA[NPINS-1:0] == $past(PIN_IN))
        else $error("level read wrong"); // R4

    // register writes land on the completing edge
    a_dir_write: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R17
        (wr_go && AVS_ADDRESS == OFS_DIR) |=> dir_r == $past(AVS_WRITEDATA[NPINS-1:0]))
        else $error("direction write lost");
    a_level_write: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R18
        (wr_go && AVS_ADDRESS == OFS_LEVEL) |=> lat_r == $past(AVS_WRITEDATA[NPINS-1:0]))
        else $error("level write lost");
    a_latch_write: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R19
        (wr_go && AVS_ADDRESS == OFS_LATCH) |=> lat_r == $past(AVS_WRITEDATA[NPINS-1:0]))
        else $error("latch write lost");
    a_odc_write: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R20
        (wr_go && AVS_ADDRESS == OFS_ODC) |=> odc_r == $past(AVS_WRITEDATA[NPINS-1:0]))
        else $error("open drain write lost");
    a_cnen_lo_write: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R15
        (wr_go && AVS_ADDRESS == OFS_CNEN_LO) |=> cnen_r[15:0] == $past(AVS_WRITEDATA[15:0]))
        else $error("enable low write lost");
    a_cnen_hi_write: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R15
        (wr_go && AVS_ADDRESS == OFS_CNEN_HI) |=> cnen_r[NCN-1:16] == $past(AVS_WRITEDATA[7:0]))
        else $error("enable high write lost");
    a_cnpu_lo_write: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R16
        (wr_go && AVS_ADDRESS == OFS_CNPU_LO) |=> cnpu_r[15:0] == $past(AVS_WRITEDATA[15:0]))
        else $error("pull-up low write lost");
    a_cnpu_hi_write: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R16
        (wr_go && AVS_ADDRESS == OFS_CNPU_HI) |=> cnpu_r[NCN-1:16] == $past(AVS_WRITEDATA[7:0]))
        else $error("pull-up high write lost");
    a_pullup_out: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R16
        (wr_go && AVS_ADDRESS == OFS_CNPU_LO) |=> CN_PULLUP_EN[15:0] == $past(AVS_WRITEDATA[15:0]))
        else $error("pull-up pin wrong");

    // sticky flag: only a clear without a change lowers it
    a_flag_clear: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R21
        (wr_go && AVS_ADDRESS == OFS_CNFLAG && AVS_WRITEDATA[0] && !cn_change) |=> !CN_IRQ)
        else $error("flag clear lost");
    a_flag_sticky: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R21
        (CN_IRQ && !(wr_go && AVS_ADDRESS == OFS_CNFLAG && AVS_WRITEDATA[0])) |=> CN_IRQ)
        else $error("flag dropped by itself");

    // ownership on other pins and peripherals
    a_module_owns_top: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R1
        (own_mod[NPINS-1] && !odc_r[NPINS-1]) |-> PIN_OUT[NPINS-1] == own_out[NPINS-1])
        else $error("top pin owner lost data");
    a_serial_ignores: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R9
        own_mod[0] |-> PERIPH_IN[0] == PIN_IN[0])
        else $error("port reached serial input");
    a_prio_second: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R6
        (!(PERIPH_EN[0][0] && PERIPH_MODULE_CTL[0][0]) && PERIPH_EN[1][0]
         && PERIPH_MODULE_CTL[1][0]) |-> own_out[0] == PERIPH_OUT[1][0])
        else $error("second peripheral not granted");
    a_input_only: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R7
        (!PERIPH_MODULE_CTL[0][0] && !PERIPH_MODULE_CTL[1][0]) |-> !own_mod[0])
        else $error("input function took driver");
    a_ext_int_loop: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R11
        (!own_mod[1] && !dir_r[1]) |-> PERIPH_IN[1] == lat_r[1])
        else $error("interrupt loopback broken");
    a_unused_output: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R13
        (!own_mod[NPINS-1] && !dir_r[NPINS-1] && !odc_r[NPINS-1]) |-> !PIN_OE_N[NPINS-1])
        else $error("unused pin not driving");
    a_od_low_top: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R20
        odc_r[NPINS-1] |-> PIN_OUT[NPINS-1] == 1'b0)
        else $error("open drain top drove high");

    // read data stands until the next read is taken
    a_read_hold: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R18
        !rd_go |=> $stable(AVS_READDATA))
        else $error("read data moved");
    a_rdata_zero_hi: assert property (@(posedge CLOCK) disable iff (!RESET_N) // R19
        (rd_go && AVS_ADDRESS == OFS_LATCH) |=> AVS_READDATA[31:NPINS] == '0)
        else $error("latch read upper bits set");
    a_wait_once: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("more than one wait state");
endmodule : pomux_top

// file: testbench/pomux_far.sv
`timescale 1ns/1ps
module pomux_far
    import pomux_pkg::*;
(
    input wire logic [POMUX_NPINS-1:0] PIN_OUT,
    input wire logic [POMUX_NPINS-1:0] PIN_OE_N,
    input wire logic [POMUX_NPINS-1:0] EXT,
    output logic [POMUX_NPINS-1:0] PIN_IN
);
    // a released pin shows the outside circuit, never the last driven level
    assign PIN_IN = (PIN_OUT & ~PIN_OE_N) | (EXT & PIN_OE_N);
endmodule : pomux_far

// file: testbench/test_pin_ownership_mux_change_notify.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_pin_ownership_mux_change_notify;
    import pomux_pkg::*;
    logic clk, rst_n, rd, wr, wq, irq;
    logic [3:0] addr;
    logic [31:0] wd, rdat, got;
    logic [1:0][15:0] pen, pmc, pout, poe;
    logic [15:0] pin_in, pin_out, oe_n, pin_per, ext, lat, x;
    logic [23:0] cn_in, cn_pu;
    int failures = 0;
    int comparisons = 0;
    pomux_top dut (.CLOCK(clk), .RESET_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wq),
        .PERIPH_EN(pen), .PERIPH_MODULE_CTL(pmc), .PERIPH_OUT(pout), .PERIPH_OE(poe),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_N(oe_n), .PERIPH_IN(pin_per),
        .CN_IN(cn_in), .CN_PULLUP_EN(cn_pu), .CN_IRQ(irq));
    pomux_far far (.PIN_OUT(pin_out), .PIN_OE_N(oe_n), .EXT(ext), .PIN_IN(pin_in));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic complete_run();
        $display("comparisons=%0d failures=%0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    // one idle cycle between requests keeps each strobe to one assignment per step
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (wq === 1'b0) break;
        end
        got = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n == 50) begin
            failures++;
            complete_run();
        end
    endtask : bus
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask : cyc
    initial begin
        {rst_n, rd, wr, addr, wd, pen, pmc, pout, poe, ext, cn_in} = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        void'($urandom(32'h9E3862FF));
        // converter pin config bits are taken as set, so every pin is a port
        bus(1'b0, OFS_DIR, 32'h0);
        `CHK(got[15:0], RST_DIR)
        `CHK(oe_n, 16'hFFFF)
        lat = 16'($urandom);
        bus(1'b1, OFS_LATCH, {16'h0000, lat});
        bus(1'b1, OFS_DIR, 32'h0);
        cyc(0);
        `CHK(pin_out, lat)
        `CHK(oe_n, 16'h0000)
        bus(1'b0, OFS_LATCH, 32'h0);
        `CHK(got, {16'h0000, lat})
        lat = 16'($urandom);
        bus(1'b1, OFS_LEVEL, {16'h0000, lat});
        bus(1'b0, OFS_LEVEL, 32'h0);
        `CHK(got[15:0], lat)
        pen <= {16'h0000, 16'hFFFF};
        cyc(1);
        `CHK(pin_per, lat)
        `CHK(pin_out, lat)
        @(posedge clk);
        ext <= 16'($urandom);
        bus(1'b1, OFS_DIR, 32'h0000FF00);
        bus(1'b0, OFS_LEVEL, 32'h0);
        `CHK(got[15:0], {ext[15:8], lat[7:0]})
        `CHK(oe_n, 16'hFF00)
        pout <= $urandom;
        poe <= $urandom;
        pen <= '1;
        pmc <= '1;
        bus(1'b1, OFS_LATCH, {16'h0000, ~lat});
        cyc(0);
        `CHK(pin_out, pout[0])
        `CHK(oe_n, ~poe[0])
        `CHK(pin_per, (pout[0] & poe[0]) | (ext & ~poe[0]))
        bus(1'b1, OFS_DIR, 32'h0);
        cyc(0);
        `CHK(pin_out, pout[0])
        @(posedge clk);
        pen <= {16'hFFFF, 16'h0000};
        cyc(1);
        `CHK(pin_out, pout[1])
        @(posedge clk);
        pen <= '0;
        bus(1'b1, OFS_ODC, 32'h0000FFFF);
        cyc(0);
        `CHK(pin_out, 16'h0000)
        `CHK(oe_n, ~lat)
        bus(1'b1, OFS_ODC, 32'h0);
        x = 16'($urandom);
        bus(1'b1, OFS_CNPU_LO, {16'h0000, x});
        bus(1'b1, OFS_CNPU_HI, {24'h0, x[15:8]});
        cyc(0);
        `CHK(cn_pu, {x[15:8], x})
        bus(1'b1, OFS_CNEN_LO, 32'h1);
        bus(1'b1, OFS_CNFLAG, 32'h1);
        cn_in <= 24'h000002;
        cyc(6);
        `CHK(irq, 1'b0)
        @(posedge clk);
        cn_in <= 24'h000003;
        cyc(4);
        `CHK(irq, 1'b1)
        cyc(8);
        `CHK(irq, 1'b1)
        bus(1'b1, OFS_CNFLAG, 32'h1);
        cyc(0);
        `CHK(irq, 1'b0)
        bus(1'b1, OFS_CNEN_HI, 32'h1);
        cn_in <= 24'h010003;
        cyc(4);
        `CHK(irq, 1'b1)
        bus(1'b0, OFS_CNFLAG, 32'h0);
        `CHK(got[0], 1'b1)
        bus(1'b0, 4'hF, 32'h0);
        `CHK(got, RD_UNMAPPED)
        complete_run();
    end
endmodule : test_pin_ownership_mux_change_notify
